/* verilog/armaf_consts.vh */
`ifndef ARMAF_CONSTS_VH
`define ARMAF_CONSTS_VH

// Direct host byte addresses
`define ARMAF_ADDR_TABLE_SEL     8'h6E
`define ARMAF_ADDR_IND_OFFSET    8'h6F
`define ARMAF_ADDR_IND_DATA      8'hA0

// Table-select layout
`define ARMAF_SEL_TABLE_HI       7
`define ARMAF_SEL_TABLE_LO       5
`define ARMAF_SEL_PORT_HI        3
`define ARMAF_SEL_PORT_LO        0
`define ARMAF_TABLE_ACL          3'h2

// Staging byte offsets
`define ARMAF_OFS_PROTO_GATE     8'h05
`define ARMAF_OFS_FLAG_MASK      8'h06
`define ARMAF_OFS_FLAG_VALUE     8'h07
`define ARMAF_OFS_RSVD_EIGHT     8'h08
`define ARMAF_OFS_RSVD_NINE      8'h09
`define ARMAF_OFS_LEVEL_ACTION   8'h0A
`define ARMAF_OFS_FORWARD_ACTION 8'h0B
`define ARMAF_OFS_CASCADE_UPPER  8'h0C

// Reset values
`define ARMAF_RST_BYTE           8'h00
`define ARMAF_RST_SELECT         8'h00

// Field codes
`define ARMAF_MODE_NONE          2'h0
`define ARMAF_MODE_HIGHER        2'h1
`define ARMAF_MODE_LOWER         2'h2
`define ARMAF_MODE_REPLACE       2'h3
`define ARMAF_KIND_COUNT         2'h1
`define ARMAF_ENABLE_COUNT       2'h0

// Timing
`define ARMAF_CLK_PERIOD_NS      4
`define ARMAF_US_NS              1000
`define ARMAF_MS_US              1000
`define ARMAF_US_CYCLES          (`ARMAF_US_NS / `ARMAF_CLK_PERIOD_NS)

`endif

/* verilog/armaf_rule_fields.v */
`timescale 1ns/1ps
`include "armaf_consts.vh"

module armaf_rule_fields #(
  parameter NPORT     = 5,
  parameter US_CYCLES = `ARMAF_US_CYCLES,
  parameter MS_US     = `ARMAF_MS_US
) (
  input  wire         ref_clk_i,
  input  wire         reset_i,
  input  wire [7:0]   reg_addr_i,
  input  wire         reg_wr_i,
  input  wire         reg_rd_i,
  input  wire [7:0]   reg_wdata_i,
  output reg  [7:0]   reg_rdata_o,
  output reg          reg_rvalid_o,
  input  wire         pkt_valid_i,
  input  wire [2:0]   pkt_port_i,
  input  wire [6:0]   pkt_proto_i,
  input  wire [7:0]   pkt_tcp_flags_i,
  input  wire [2:0]   pkt_qos_level_i,
  input  wire [4:0]   pkt_lut_map_i,
  input  wire [1:0]   rule_match_kind_i,
  input  wire [1:0]   rule_field_enable_i,
  output reg          res_valid_o,
  output reg          res_hit_o,
  output reg  [2:0]   res_level_o,
  output reg          res_remark_enable_o,
  output reg  [2:0]   res_remark_level_o,
  output reg  [4:0]   res_fwd_map_o,
  output reg  [7:0]   res_cascade_upper_o,
  output reg  [NPORT-1:0] count_expire_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function sel_is_acl_port;
    input [7:0] sel;
    begin
      sel_is_acl_port = (sel[`ARMAF_SEL_TABLE_HI:`ARMAF_SEL_TABLE_LO] == `ARMAF_TABLE_ACL) &&
                        (sel[`ARMAF_SEL_PORT_HI:`ARMAF_SEL_PORT_LO] >= 4'h1) &&
                        (sel[`ARMAF_SEL_PORT_HI:`ARMAF_SEL_PORT_LO] <= NPORT);
    end
  endfunction

  function port_in_range;
    input [2:0] port;
    begin
      port_in_range = (port >= 3'h1) && (port <= NPORT);
    end
  endfunction

  // Invalid ports fold onto slot zero so array reads never leave the range
  function [2:0] port_slot;
    input [3:0] port;
    begin
      if ((port >= 4'h1) && (port <= NPORT))
        port_slot = port[2:0] - 3'h1;
      else
        port_slot = 3'h0;
    end
  endfunction

  // Only these offsets hold storage; reserved offsets never latch a write
  function ofs_is_stored;
    input [7:0] ofs;
    begin
      case (ofs)
        `ARMAF_OFS_PROTO_GATE,
        `ARMAF_OFS_FLAG_MASK,
        `ARMAF_OFS_FLAG_VALUE,
        `ARMAF_OFS_LEVEL_ACTION,
        `ARMAF_OFS_FORWARD_ACTION,
        `ARMAF_OFS_CASCADE_UPPER: ofs_is_stored = 1'b1;
        default:                  ofs_is_stored = 1'b0;
      endcase
    end
  endfunction

  function [2:0] level_pick;
    input [1:0] mode;
    input [2:0] rule_level;
    input [2:0] qos_level;
    begin
      case (mode)
        `ARMAF_MODE_NONE:    level_pick = qos_level;
        `ARMAF_MODE_HIGHER:  level_pick = (rule_level > qos_level) ? rule_level : qos_level;
        `ARMAF_MODE_LOWER:   level_pick = (rule_level < qos_level) ? rule_level : qos_level;
        `ARMAF_MODE_REPLACE: level_pick = rule_level;
        default:             level_pick = qos_level;
      endcase
    end
  endfunction

  function [4:0] map_pick;
    input [1:0] mode;
    input [4:0] rule_map;
    input [4:0] lut_map;
    begin
      case (mode)
        `ARMAF_MODE_NONE:    map_pick = lut_map;
        `ARMAF_MODE_HIGHER:  map_pick = rule_map | lut_map;
        `ARMAF_MODE_LOWER:   map_pick = rule_map & lut_map;
        `ARMAF_MODE_REPLACE: map_pick = rule_map;
        default:             map_pick = lut_map;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Host-visible select and offset

  reg  [7:0] table_select;
  reg  [7:0] ind_offset;
  wire       sel_ok  = sel_is_acl_port(table_select);
  wire [2:0] sel_idx = port_slot(table_select[3:0]);
  wire       data_wr = reg_wr_i && (reg_addr_i == `ARMAF_ADDR_IND_DATA) && sel_ok &&
                       ofs_is_stored(ind_offset);

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      table_select <= `ARMAF_RST_SELECT;
      ind_offset   <= `ARMAF_RST_BYTE;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `ARMAF_ADDR_TABLE_SEL)
        table_select <= reg_wdata_i;
      if (reg_addr_i == `ARMAF_ADDR_IND_OFFSET)
        ind_offset <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port staging bytes

  reg [7:0] protocol_and_flag_gate [0:NPORT-1];
  reg [7:0] tcp_flag_bitmask_byte  [0:NPORT-1];
  reg [7:0] tcp_flag_value_byte    [0:NPORT-1];
  reg [7:0] level_action_byte      [0:NPORT-1];
  reg [7:0] forward_action_byte    [0:NPORT-1];
  reg [7:0] cascade_select_upper   [0:NPORT-1];

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp = gp + 1) begin : g_store
      wire hit_port = data_wr && (sel_idx == gp);
      always @(posedge ref_clk_i) begin
        if (reset_i) begin
          protocol_and_flag_gate[gp] <= `ARMAF_RST_BYTE;
          tcp_flag_bitmask_byte[gp]  <= `ARMAF_RST_BYTE;
          tcp_flag_value_byte[gp]    <= `ARMAF_RST_BYTE;
          level_action_byte[gp]      <= `ARMAF_RST_BYTE;
          forward_action_byte[gp]    <= `ARMAF_RST_BYTE;
          cascade_select_upper[gp]   <= `ARMAF_RST_BYTE;
        end else if (hit_port) begin
          case (ind_offset)
            `ARMAF_OFS_PROTO_GATE:     protocol_and_flag_gate[gp] <= reg_wdata_i;
            `ARMAF_OFS_FLAG_MASK:      tcp_flag_bitmask_byte[gp]  <= reg_wdata_i;
            `ARMAF_OFS_FLAG_VALUE:     tcp_flag_value_byte[gp]    <= reg_wdata_i;
            `ARMAF_OFS_LEVEL_ACTION:   level_action_byte[gp]      <= reg_wdata_i;
            `ARMAF_OFS_FORWARD_ACTION: forward_action_byte[gp]    <= reg_wdata_i;
            `ARMAF_OFS_CASCADE_UPPER:  cascade_select_upper[gp]   <= reg_wdata_i;
            default: ;
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Host read path

  reg [7:0] staged_byte;

  always @* begin
    staged_byte = `ARMAF_RST_BYTE;
    if (sel_ok) begin
      case (ind_offset)
        `ARMAF_OFS_PROTO_GATE:     staged_byte = protocol_and_flag_gate[sel_idx];
        `ARMAF_OFS_FLAG_MASK:      staged_byte = tcp_flag_bitmask_byte[sel_idx];
        `ARMAF_OFS_FLAG_VALUE:     staged_byte = tcp_flag_value_byte[sel_idx];
        `ARMAF_OFS_RSVD_EIGHT:     staged_byte = `ARMAF_RST_BYTE;
        `ARMAF_OFS_RSVD_NINE:      staged_byte = `ARMAF_RST_BYTE;
        `ARMAF_OFS_LEVEL_ACTION:   staged_byte = level_action_byte[sel_idx];
        `ARMAF_OFS_FORWARD_ACTION: staged_byte = forward_action_byte[sel_idx];
        `ARMAF_OFS_CASCADE_UPPER:  staged_byte = cascade_select_upper[sel_idx];
        default:                   staged_byte = `ARMAF_RST_BYTE;
      endcase
    end
  end

  reg [7:0] next_rdata;

  always @* begin
    case (reg_addr_i)
      `ARMAF_ADDR_TABLE_SEL:   next_rdata = table_select;
      `ARMAF_ADDR_IND_OFFSET:  next_rdata = ind_offset;
      `ARMAF_ADDR_IND_DATA:    next_rdata = staged_byte;
      default:                 next_rdata = 8'h00;
    endcase
  end

  // Read data holds until the next read so slow hosts can sample late
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase: one-cycle microsecond and millisecond enables

  reg [15:0] us_div;
  reg [15:0] ms_div;
  reg        us_tick;
  reg        ms_tick;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      us_div  <= 16'h0000;
      ms_div  <= 16'h0000;
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
    end else begin
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
      if (us_div == US_CYCLES - 1) begin
        us_div  <= 16'h0000;
        us_tick <= 1'b1;
        if (ms_div == MS_US - 1) begin
          ms_div  <= 16'h0000;
          ms_tick <= 1'b1;
        end else begin
          ms_div <= ms_div + 16'h0001;
        end
      end else begin
        us_div <= us_div + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rule evaluation for the arriving packet

  wire       pkt_ok   = port_in_range(pkt_port_i);
  wire [2:0] pkt_idx  = port_slot({1'b0, pkt_port_i});
  wire [7:0] gate_b   = protocol_and_flag_gate[pkt_idx];
  wire [7:0] mask_b   = tcp_flag_bitmask_byte[pkt_idx];
  wire [7:0] value_b  = tcp_flag_value_byte[pkt_idx];
  wire [7:0] level_b  = level_action_byte[pkt_idx];
  wire [7:0] fwd_b    = forward_action_byte[pkt_idx];
  wire       proto_eq = (pkt_proto_i == gate_b[7:1]);
  // Masked compare; a zero mask lets any flag pattern through
  wire       flag_eq  = ~gate_b[0] ||
                        ((pkt_tcp_flags_i & mask_b) == (value_b & mask_b));
  wire       rule_hit = pkt_ok && proto_eq && flag_eq;
  wire       counting = (rule_match_kind_i == `ARMAF_KIND_COUNT) &&
                        (rule_field_enable_i == `ARMAF_ENABLE_COUNT);

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      res_valid_o         <= 1'b0;
      res_hit_o           <= 1'b0;
      res_level_o         <= 3'h0;
      res_remark_enable_o <= 1'b0;
      res_remark_level_o  <= 3'h0;
      res_fwd_map_o       <= 5'h00;
      res_cascade_upper_o <= 8'h00;
    end else begin
      res_valid_o <= pkt_valid_i;
      if (pkt_valid_i) begin
        res_hit_o           <= rule_hit;
        res_cascade_upper_o <= pkt_ok ? cascade_select_upper[pkt_idx] : 8'h00;
        if (rule_hit) begin
          res_level_o         <= level_pick(level_b[7:6], level_b[5:3],
                                            pkt_qos_level_i);
          res_remark_enable_o <= level_b[2];
          res_remark_level_o  <= {level_b[1:0], fwd_b[7]};
          // Map bits are timer settings when counting, so the lookup map stands
          if (counting)
            res_fwd_map_o <= pkt_lut_map_i;
          else
            res_fwd_map_o <= map_pick(fwd_b[6:5], fwd_b[4:0], pkt_lut_map_i);
        end else begin
          res_level_o         <= pkt_qos_level_i;
          res_remark_enable_o <= 1'b0;
          res_remark_level_o  <= 3'h0;
          res_fwd_map_o       <= pkt_lut_map_i;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port 11-bit timer / match counter

  generate
    for (gp = 0; gp < NPORT; gp = gp + 1) begin : g_count
      reg  [10:0] cnt;
      reg         running;
      wire [10:0] limit    = {level_action_byte[gp], forward_action_byte[gp][7:5]};
      wire        count_up = forward_action_byte[gp][3];
      wire        tick     = forward_action_byte[gp][4] ? ms_tick : us_tick;
      wire        match    = pkt_valid_i && rule_hit && counting && (pkt_idx == gp);
      always @(posedge ref_clk_i) begin
        if (reset_i) begin
          cnt               <= 11'h000;
          running           <= 1'b0;
          count_expire_o[gp] <= 1'b0;
        end else begin
          count_expire_o[gp] <= 1'b0;
          if (!counting) begin
            cnt     <= 11'h000;
            running <= 1'b0;
          end else if (count_up) begin
            running <= 1'b0;
            if (match) begin
              if (cnt + 11'h001 >= limit) begin
                cnt                <= 11'h000;
                count_expire_o[gp] <= 1'b1;
              end else begin
                cnt <= cnt + 11'h001;
              end
            end
          end else if (running) begin
            if (tick) begin
              if (cnt == 11'h000) begin
                running            <= 1'b0;
                count_expire_o[gp] <= 1'b1;
              end else begin
                cnt <= cnt - 11'h001;
              end
            end
          end else if (match) begin
            // Timer arms on a matching packet and ignores further matches until it expires
            cnt     <= limit;
            running <= 1'b1;
          end
        end
      end
    end
  endgenerate

endmodule

/* tb/armaf_rule_fields_checker.sv */
`timescale 1ns/1ps
module armaf_rule_fields_checker #(
  parameter NPORT = 5
) (
  input wire logic             ref_clk_i, reset_i, reg_wr_i, reg_rd_i, reg_rvalid_o,
  input wire logic [7:0]       reg_addr_i, reg_wdata_i, reg_rdata_o,
  input wire logic             pkt_valid_i, res_valid_o, res_hit_o, res_remark_enable_o,
  input wire logic [2:0]       pkt_port_i, pkt_qos_level_i, res_level_o, res_remark_level_o,
  input wire logic [6:0]       pkt_proto_i,
  input wire logic [7:0]       pkt_tcp_flags_i, res_cascade_upper_o,
  input wire logic [4:0]       pkt_lut_map_i, res_fwd_map_o,
  input wire logic [1:0]       rule_match_kind_i, rule_field_enable_i,
  input wire logic [NPORT-1:0] count_expire_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence read_taken;
    reg_rd_i;
  endsequence
  sequence lookup_miss;
    pkt_valid_i ##1 (res_valid_o && !res_hit_o);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  read_answer_a: assert property (read_taken |=> reg_rvalid_o)
    else $error("read not answered in one cycle");
  read_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("read valid without a read");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  lookup_answer_a: assert property (pkt_valid_i |=> res_valid_o)
    else $error("lookup not answered in one cycle");
  lookup_cause_a: assert property (res_valid_o |-> $past(pkt_valid_i))
    else $error("result valid without a lookup");
  // A miss must leave the packet's own priority and map untouched
  miss_default_a: assert property (lookup_miss |-> res_level_o == $past(pkt_qos_level_i)
    && res_fwd_map_o == $past(pkt_lut_map_i)) else $error("miss altered level or map");
  bad_port_a: assert property (pkt_valid_i && (pkt_port_i == 3'h0 || pkt_port_i > 3'h5)
    |=> !res_hit_o && !res_remark_enable_o && res_cascade_upper_o == 8'h00)
    else $error("invalid port produced a rule action");
  hit_port_a: assert property (res_valid_o && res_hit_o |-> $past(pkt_port_i) inside {[1:5]})
    else $error("hit on an invalid port");
  expire_kind_a: assert property (count_expire_o != 0 |-> $past(rule_match_kind_i) == 2'h1
    && $past(rule_field_enable_i) == 2'h0) else $error("expiry outside counting case");
endmodule
bind armaf_rule_fields armaf_rule_fields_checker #(.NPORT(NPORT)) u_chk (.ref_clk_i, .reset_i,
  .reg_wr_i, .reg_rd_i, .reg_rvalid_o, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .pkt_valid_i,
  .res_valid_o, .res_hit_o, .res_remark_enable_o, .pkt_port_i, .pkt_qos_level_i, .res_level_o,
  .res_remark_level_o, .pkt_proto_i, .pkt_tcp_flags_i, .res_cascade_upper_o, .pkt_lut_map_i,
  .res_fwd_map_o, .rule_match_kind_i, .rule_field_enable_i, .count_expire_o);

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "armaf_consts.vh"
module testbench;
  logic       ref_clk_i, reset_i, reg_wr_i, reg_rd_i, reg_rvalid_o, pkt_valid_i;
  logic       res_valid_o, res_hit_o, res_remark_enable_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pkt_tcp_flags_i, res_cascade_upper_o;
  logic [2:0] pkt_port_i, pkt_qos_level_i, res_level_o, res_remark_level_o;
  logic [6:0] pkt_proto_i;
  logic [4:0] pkt_lut_map_i, res_fwd_map_o, count_expire_o;
  logic [1:0] rule_match_kind_i, rule_field_enable_i;
  int         n_errors = 0;
  int         checks_done = 0;
  // Short tick counts keep the millisecond case inside the run budget
  armaf_rule_fields #(.NPORT(5), .US_CYCLES(4), .MS_US(3)) u_armaf_rule_fields (.ref_clk_i,
    .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
    .pkt_valid_i, .pkt_port_i, .pkt_proto_i, .pkt_tcp_flags_i, .pkt_qos_level_i, .pkt_lut_map_i,
    .rule_match_kind_i, .rule_field_enable_i, .res_valid_o, .res_hit_o, .res_level_o,
    .res_remark_enable_o, .res_remark_level_o, .res_fwd_map_o, .res_cascade_upper_o,
    .count_expire_o);
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("read valid", reg_rvalid_o, 1'b1);
    chk(what, reg_rdata_o, exp);
  endtask
  task automatic acc(logic [3:0] p, logic [7:0] o);
    wr(`ARMAF_ADDR_TABLE_SEL, {3'h2, 1'b0, p});
    wr(`ARMAF_ADDR_IND_OFFSET, o);
  endtask
  task automatic put(logic [3:0] p, logic [7:0] o, logic [7:0] d);
    acc(p, o);
    wr(`ARMAF_ADDR_IND_DATA, d);
  endtask
  task automatic get(logic [3:0] p, logic [7:0] o, logic [7:0] exp, string what);
    acc(p, o);
    rd(`ARMAF_ADDR_IND_DATA, exp, what);
  endtask
  task automatic pk(logic [2:0] p, logic [6:0] pr, logic [7:0] fl, logic [2:0] q, logic [4:0] m);
    @(posedge ref_clk_i);
    pkt_valid_i <= 1'b1;
    pkt_port_i <= p;
    pkt_proto_i <= pr;
    pkt_tcp_flags_i <= fl;
    pkt_qos_level_i <= q;
    pkt_lut_map_i <= m;
    @(posedge ref_clk_i);
    pkt_valid_i <= 1'b0;
    #1;
    chk("result valid", res_valid_o, 1'b1);
  endtask
  // Bounded wait for the port 1 expiry pulse, judged against a cycle window
  task automatic wait_expire(string what, int lo, int hi);
    int n;
    for (n = 0; n < 100 && count_expire_o[0] !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    if (n == 100) begin
      n_errors++;
      conclude();
    end else begin
      chk(what, n >= lo && n <= hi, 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int p = 1; p <= 5; p++)
      for (int o = 5; o <= 12; o++) get(p, o, 8'h00, "reset byte");
  endtask
  task automatic t_regs;
    for (int o = 5; o <= 12; o++) put(3, o, {o[3:0], ~o[3:0]});
    for (int o = 5; o <= 12; o++)
      get(3, o, (o == 8 || o == 9) ? 8'h00 : {o[3:0], ~o[3:0]}, "staged byte");
    get(4, 6, 8'h00, "other port byte");
    rd(8'h50, 8'h00, "unmapped address");
    wr(`ARMAF_ADDR_TABLE_SEL, 8'h63);
    rd(`ARMAF_ADDR_IND_DATA, 8'h00, "foreign table");
  endtask
  task automatic t_match;
    put(2, 5, {7'h06, 1'b1});
    put(2, 6, 8'h12);
    put(2, 7, 8'h02);
    pk(2, 7'h06, 8'hE2, 3'h3, 5'h13);
    chk("masked flags hit", res_hit_o, 1'b1);
    pk(2, 7'h06, 8'h10, 3'h3, 5'h13);
    chk("flag miss", res_hit_o, 1'b0);
    pk(2, 7'h07, 8'h02, 3'h3, 5'h13);
    chk("protocol miss", res_hit_o, 1'b0);
    put(2, 5, {7'h06, 1'b0});
    pk(2, 7'h06, 8'h10, 3'h3, 5'h13);
    chk("flags ignored", res_hit_o, 1'b1);
    pk(6, 7'h06, 8'h10, 3'h3, 5'h13);
    chk("bad port", res_hit_o, 1'b0);
  endtask
  task automatic t_level;
    logic [2:0] q;
    logic [2:0] e;
    put(2, 11, 8'h80);
    for (int m = 0; m < 4; m++) begin
      put(2, 10, {m[1:0], 3'h5, 1'b1, 2'h2});
      for (int k = 0; k < 2; k++) begin
        q = k ? 3'h6 : 3'h3;
        e = (m == 0) ? q : (m == 1) ? ((3'h5 > q) ? 3'h5 : q) :
            (m == 2) ? ((3'h5 < q) ? 3'h5 : q) : 3'h5;
        pk(2, 7'h06, 8'h00, q, 5'h13);
        chk("level", res_level_o, e);
        chk("remark enable", res_remark_enable_o, 1'b1);
        chk("remark level", res_remark_level_o, 3'h5);
      end
    end
  endtask
  task automatic t_map;
    logic [4:0] e[4] = '{5'h13, 5'h1B, 5'h02, 5'h0A};
    put(2, 10, 8'h00);
    put(2, 12, 8'hC3);
    for (int m = 0; m < 4; m++) begin
      put(2, 11, {1'b0, m[1:0], 5'h0A});
      pk(2, 7'h06, 8'h00, 3'h0, 5'h13);
      chk("forward map", res_fwd_map_o, e[m]);
      chk("remark off", res_remark_enable_o, 1'b0);
    end
    chk("cascade upper", res_cascade_upper_o, 8'hC3);
  endtask
  task automatic t_count;
    put(1, 5, {7'h06, 1'b0});
    put(1, 10, 8'h00);
    put(1, 11, 8'h68);
    @(posedge ref_clk_i);
    rule_match_kind_i <= 2'h1;
    rule_field_enable_i <= 2'h0;
    for (int i = 0; i < 3; i++) begin
      pk(1, 7'h06, 8'h00, 3'h0, 5'h13);
      chk("count up expiry", count_expire_o, (i == 2) ? 5'h01 : 5'h00);
    end
    chk("counting map", res_fwd_map_o, 5'h13);
    put(1, 11, 8'h40);
    pk(1, 7'h06, 8'h00, 3'h0, 5'h13);
    wait_expire("microsecond countdown", 6, 16);
    put(1, 11, 8'h30);
    pk(1, 7'h06, 8'h00, 3'h0, 5'h13);
    wait_expire("millisecond countdown", 12, 30);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    n_errors++;
    conclude();
  end
  initial begin
    reset_i = 1'b1;
    {reg_wr_i, reg_rd_i, pkt_valid_i} = 3'h0;
    {reg_addr_i, reg_wdata_i, pkt_tcp_flags_i} = 24'h000000;
    {pkt_port_i, pkt_qos_level_i, pkt_proto_i, pkt_lut_map_i} = 18'h00000;
    {rule_match_kind_i, rule_field_enable_i} = 4'h0;
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_regs();
    t_match();
    t_level();
    t_map();
    t_count();
    conclude();
  end
endmodule
